// ===== src/eies_pkg.sv
// Purpose: Shared constants for the Ethernet interrupt enable and status block.
// Assumes: AXI4-Lite register access, 32-bit data, one aligned word per register.
// Notes:   Printed offsets are register indices; byte address is four times the index.
package eies_pkg;

  // Register indices as printed, and the derived byte addresses
  localparam logic [7:0]  IDX_MASK       = 8'h90;
  localparam logic [7:0]  IDX_FLAGS      = 8'h92;
  localparam int          ADDR_W         = 12;
  localparam logic [11:0] ADDR_MASK      = {2'h0, IDX_MASK, 2'h0};
  localparam logic [11:0] ADDR_FLAGS     = {2'h0, IDX_FLAGS, 2'h0};

  // Bit positions shared by the enable mask and the status flags
  localparam int BIT_LINK_CHANGE  = 15;
  localparam int BIT_TX_DONE      = 14;
  localparam int BIT_RX_READY     = 13;
  localparam int BIT_RX_OVERRUN   = 11;
  localparam int BIT_TX_STOPPED   = 9;
  localparam int BIT_RX_STOPPED   = 8;
  localparam int BIT_TX_SPACE     = 6;
  localparam int BIT_WAKE_FRAME   = 5;
  localparam int BIT_MAGIC_PACKET = 4;
  localparam int BIT_LINKUP_WAKE  = 3;
  localparam int BIT_ENERGY_WAKE  = 2;
  localparam int BIT_RSVD_RO      = 1;
  localparam int BIT_DELAYED_EN   = 0;
  localparam int WAKE_LO          = 2;
  localparam int WAKE_W           = 4;

  // Reset values and access masks
  localparam logic [15:0] MASK_RESET     = 16'h0000;
  localparam logic [15:0] MASK_WRITABLE  = 16'hFFFD;
  localparam logic [15:0] FLAGS_RESET    = 16'h0300;
  localparam logic [15:0] FLAGS_W1C      = 16'hEB40;
  localparam int          REG_W          = 16;

  // AXI responses
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;

endpackage : eies_pkg

// ===== src/eies_irq_ctrl.sv
// Overview of operation
// [R1] Mask bit 15 gates link change interrupt.
// [R2] Mask bit 14 gates frame transmitted interrupt.
// [R3] Mask bit 13 gates frame received interrupt.
// [R4] Mask bit 11 gates receive overrun interrupt.
// [R5] Mask bit 9 gates transmit stopped interrupt.
// [R6] Mask bit 8 gates receive stopped interrupt.
// [R7] Mask bit 6 gates transmit space interrupt.
// [R8] Mask bit 5 gates wake frame interrupt.
// [R9] Mask bit 4 gates magic packet interrupt.
// [R10] Mask bit 3 gates linkup wake interrupt.
// [R11] Mask bit 2 gates energy wake interrupt.
// [R12] Mask bit 0 gates delayed energy interrupt.
// [R13] Delayed energy waits for device ready.
// [R14] Mask resets zero; bit 1 read-only.
// [R15] Pin asserts when enabled flag set.
// [R16] Reads never clear; write one clears all but the wake flags.
// [R17] Flags latch on event edge until cleared.
// [R18] Link change sets on either link edge.
// [R19] Transmit done flag sets on completion.
// [R20] Receive ready flag sets on frame ready.
// [R21] Both stopped flags reset to one.
// [R22] Overrun flag latches, cleared by one.
// [R23] Flags latch regardless of mask bits.
//
// Purpose: Interrupt mask and sticky status flags with one interrupt pin, AXI4-Lite slave.
// Assumes: Event inputs come from logic on aclk; wake flags are cleared only by pm_wake_clear.
// Notes:   Set wins over clear in the same cycle so no event is ever lost.
`timescale 1ns/1ps
module eies_irq_ctrl #(
  parameter int ADDR_W = eies_pkg::ADDR_W
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]        s_axi_awprot,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]        s_axi_arprot,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              link_up,
  input  wire logic              tx_done_evt,
  input  wire logic              rx_ready_evt,
  input  wire logic              rx_overrun_evt,
  input  wire logic              tx_stopped_evt,
  input  wire logic              rx_stopped_evt,
  input  wire logic              tx_space_evt,
  input  wire logic              wake_frame_evt,
  input  wire logic              magic_packet_evt,
  input  wire logic              linkup_wake_evt,
  input  wire logic              energy_wake_evt,
  input  wire logic              device_ready,
  input  wire logic [3:0]        pm_wake_clear,
  output logic                   irq_out
);

  localparam int RW = eies_pkg::REG_W;

  typedef struct packed {
    logic [RW-1:0]     mask;
    logic [RW-1:0]     flags;
    logic [RW-1:0]     evt_prev;
    logic              link_prev;
    logic              irq;
    logic              aw_got;
    logic [ADDR_W-1:0] aw_addr;
    logic              w_got;
    logic [31:0]       w_data;
    logic [3:0]        w_strb;
    logic              awready;
    logic              wready;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arready;
    logic              rvalid;
    logic [1:0]        rresp;
    logic [31:0]       rdata;
  } eies_state_t;

  eies_state_t st_reg;
  eies_state_t st_next;

  logic [RW-1:0] evt_now;
  logic [RW-1:0] set_vec;
  logic [RW-1:0] clr_vec;
  logic [RW-1:0] eff_en;
  logic [RW-1:0] wr_bits;
  logic          wr_fire;
  logic          rd_fire;

  // Gather the edge-sensitive sources into their flag positions
  always_comb begin
    evt_now = '0;
    evt_now[eies_pkg::BIT_TX_DONE]      = tx_done_evt;      // see [R19]
    evt_now[eies_pkg::BIT_RX_READY]     = rx_ready_evt;     // see [R20]
    evt_now[eies_pkg::BIT_RX_OVERRUN]   = rx_overrun_evt;   // see [R22]
    evt_now[eies_pkg::BIT_TX_STOPPED]   = tx_stopped_evt;
    evt_now[eies_pkg::BIT_RX_STOPPED]   = rx_stopped_evt;
    evt_now[eies_pkg::BIT_TX_SPACE]     = tx_space_evt;
    evt_now[eies_pkg::BIT_WAKE_FRAME]   = wake_frame_evt;
    evt_now[eies_pkg::BIT_MAGIC_PACKET] = magic_packet_evt;
    evt_now[eies_pkg::BIT_LINKUP_WAKE]  = linkup_wake_evt;
    evt_now[eies_pkg::BIT_ENERGY_WAKE]  = energy_wake_evt;
  end

  // Rising edge per source; link change fires on both edges of the link level
  genvar gi;
  generate
    for (gi = 0; gi < RW; gi++) begin : g_edge
      if (gi == eies_pkg::BIT_LINK_CHANGE) begin : g_link
        assign set_vec[gi] = link_up ^ st_reg.link_prev;                   // see [R18]
      end else begin : g_rise
        assign set_vec[gi] = evt_now[gi] & ~st_reg.evt_prev[gi];           // see [R17]
      end
    end
  endgenerate

  // Byte-lane merge of the held write data onto a 16-bit register
  assign wr_bits = {st_reg.w_strb[1] ? st_reg.w_data[15:8] : 8'h00,
                    st_reg.w_strb[0] ? st_reg.w_data[7:0]  : 8'h00};
  assign wr_fire = st_reg.aw_got & st_reg.w_got & ~st_reg.bvalid;
  assign rd_fire = s_axi_arvalid & st_reg.arready;

  // Write one clears host-clearable bits; wake bits clear only from power management
  always_comb begin
    clr_vec = '0;
    if (wr_fire && st_reg.aw_addr == eies_pkg::ADDR_FLAGS) begin
      clr_vec = wr_bits & eies_pkg::FLAGS_W1C;                             // see [R16]
    end
    clr_vec[eies_pkg::WAKE_LO +: eies_pkg::WAKE_W] = pm_wake_clear;
  end

  // Effective enables; delayed energy shares the energy flag but waits for ready
  always_comb begin
    eff_en = st_reg.mask;                          // see [R1] [R2] [R3] [R4] [R5] [R6] [R7] [R8] [R9] [R10]
    eff_en[eies_pkg::BIT_ENERGY_WAKE] = st_reg.mask[eies_pkg::BIT_ENERGY_WAKE]          // see [R11]
      | (st_reg.mask[eies_pkg::BIT_DELAYED_EN] & device_ready);                         // see [R12] [R13]
    eff_en[eies_pkg::BIT_DELAYED_EN] = 1'b0;
    eff_en[eies_pkg::BIT_RSVD_RO]    = 1'b0;                    // see [R14]
  end

  // Next-state logic for registers, flags and bus channels
  always_comb begin
    st_next           = st_reg;
    st_next.evt_prev  = evt_now;
    st_next.link_prev = link_up;
    // Set after clear so a simultaneous event survives the clear
    st_next.flags     = (st_reg.flags & ~clr_vec) | set_vec;                // see [R17] [R23]

    // Address and data are taken independently, in either order
    if (s_axi_awvalid && st_reg.awready) begin
      st_next.aw_got  = 1'b1;
      st_next.aw_addr = s_axi_awaddr;
      st_next.awready = 1'b0;
    end
    if (s_axi_wvalid && st_reg.wready) begin
      st_next.w_got  = 1'b1;
      st_next.w_data = s_axi_wdata;
      st_next.w_strb = s_axi_wstrb;
      st_next.wready = 1'b0;
    end

    // Write commit once both halves are held
    if (wr_fire) begin
      st_next.aw_got = 1'b0;
      st_next.w_got  = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp  = eies_pkg::RESP_OKAY;
      if (st_reg.aw_addr == eies_pkg::ADDR_MASK) begin
        st_next.mask = (st_reg.mask & ~eies_pkg::MASK_WRITABLE)
                     | (((st_reg.mask & ~{st_reg.w_strb[1] ? 8'hFF : 8'h00, st_reg.w_strb[0] ? 8'hFF : 8'h00})
                     | wr_bits) & eies_pkg::MASK_WRITABLE);                 // see [R14]
      end else if (st_reg.aw_addr != eies_pkg::ADDR_FLAGS) begin
        st_next.bresp = eies_pkg::RESP_SLVERR;
      end
    end
    if (st_reg.bvalid && s_axi_bready) begin
      st_next.bvalid  = 1'b0;
      st_next.awready = 1'b1;
      st_next.wready  = 1'b1;
    end

    // Read path; reading the flags has no side effect on them
    if (rd_fire) begin
      st_next.arready = 1'b0;
      st_next.rvalid  = 1'b1;
      st_next.rresp   = eies_pkg::RESP_OKAY;
      st_next.rdata   = 32'h0000_0000;
      if (s_axi_araddr == eies_pkg::ADDR_MASK) begin
        st_next.rdata[RW-1:0] = st_reg.mask;
      end else if (s_axi_araddr == eies_pkg::ADDR_FLAGS) begin
        st_next.rdata[RW-1:0] = st_reg.flags;                               // see [R16]
      end else begin
        st_next.rresp = eies_pkg::RESP_SLVERR;
      end
    end
    if (st_reg.rvalid && s_axi_rready) begin
      st_next.rvalid  = 1'b0;
      st_next.arready = 1'b1;
    end

    // Pin registered from the next flags so it changes on the same edge as them
    st_next.irq = |(st_next.flags & eff_en);                                // see [R15]
  end

  // State register with synchronous reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg           <= '0;
      st_reg.mask      <= eies_pkg::MASK_RESET;                             // see [R14]
      st_reg.flags     <= eies_pkg::FLAGS_RESET;                            // see [R21]
      st_reg.evt_prev  <= '1;
      st_reg.link_prev <= 1'b0;
      st_reg.awready   <= 1'b1;
      st_reg.wready    <= 1'b1;
      st_reg.arready   <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from the state register
  assign s_axi_awready = st_reg.awready;
  assign s_axi_wready  = st_reg.wready;
  assign s_axi_bvalid  = st_reg.bvalid;
  assign s_axi_bresp   = st_reg.bresp;
  assign s_axi_arready = st_reg.arready;
  assign s_axi_rvalid  = st_reg.rvalid;
  assign s_axi_rresp   = st_reg.rresp;
  assign s_axi_rdata   = st_reg.rdata;
  assign irq_out       = st_reg.irq;

  // Checks, all on aclk and disabled in reset
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic [RW-1:0] flags_q;
  assign flags_q = st_reg.flags;

  // Enables as the rules read them, kept apart from eff_en so the pin check is independent
  logic [RW-1:0] en_rule;
  always_comb begin
    en_rule = st_reg.mask & ~(16'h0001 << eies_pkg::BIT_DELAYED_EN);
    if (st_reg.mask[eies_pkg::BIT_DELAYED_EN] && device_ready) begin
      en_rule[eies_pkg::BIT_ENERGY_WAKE] = 1'b1;
    end
  end

  sequence s_link_edge;
    link_up != $past(link_up);
  endsequence

  sequence s_link_flag_set;
    ##1 flags_q[eies_pkg::BIT_LINK_CHANGE];
  endsequence

  property p_link_change;
    $past(aresetn) ##0 s_link_edge |-> s_link_flag_set;
  endproperty
  a_link_change: assert property (p_link_change) // see [R18]
    else $error("link edge did not set link change flag");

  property p_irq_pin;
    ##1 irq_out == |(flags_q & $past(en_rule));
  endproperty
  a_irq_pin: assert property (p_irq_pin) // see [R15]
    else $error("interrupt pin disagrees with enabled flags");

  property p_masked_quiet;
    (st_reg.mask == 16'h0000) && $stable(st_reg.mask) |-> !irq_out;
  endproperty
  a_masked_quiet: assert property (p_masked_quiet) // see [R1]
    else $error("interrupt pin high with all enables clear");

  property p_rsvd_ro;
    !st_reg.mask[eies_pkg::BIT_RSVD_RO];
  endproperty
  a_rsvd_ro: assert property (p_rsvd_ro) // see [R14]
    else $error("read-only mask bit became set");

  property p_read_no_clear;
    rd_fire && !wr_fire && (pm_wake_clear == 4'h0) |=> ((flags_q & $past(flags_q)) == $past(flags_q));
  endproperty
  a_read_no_clear: assert property (p_read_no_clear) // see [R16]
    else $error("flag lost without a clearing write");

  property p_set_wins;
    set_vec[eies_pkg::BIT_RX_OVERRUN] |=> flags_q[eies_pkg::BIT_RX_OVERRUN];
  endproperty
  a_set_wins: assert property (p_set_wins) // see [R22]
    else $error("overrun event lost");

  property p_w1c;
    wr_fire && st_reg.aw_addr == eies_pkg::ADDR_FLAGS && wr_bits[eies_pkg::BIT_TX_DONE]
      && !set_vec[eies_pkg::BIT_TX_DONE] |=> !flags_q[eies_pkg::BIT_TX_DONE];
  endproperty
  a_w1c: assert property (p_w1c) // see [R17]
    else $error("write of one did not clear transmit done flag");

  property p_delayed_hold;
    st_reg.mask == 16'h0001 && !device_ready && $past(st_reg.mask) == 16'h0001
      && !$past(device_ready) |-> !irq_out;
  endproperty
  a_delayed_hold: assert property (p_delayed_hold) // see [R13]
    else $error("delayed energy interrupt before device ready");

  property p_latch_unmasked;
    set_vec[eies_pkg::BIT_RX_READY] && !st_reg.mask[eies_pkg::BIT_RX_READY] |=> flags_q[eies_pkg::BIT_RX_READY];
  endproperty
  a_latch_unmasked: assert property (p_latch_unmasked) // see [R23]
    else $error("masked event not latched");

  property p_bvalid_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  a_bvalid_hold: assert property (p_bvalid_hold)
    else $error("write response dropped before taken");

  property p_rvalid_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rvalid_hold: assert property (p_rvalid_hold)
    else $error("read data dropped or changed before taken");

  property p_one_write;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_one_write: assert property (p_one_write)
    else $error("write channel open while a response is pending");

  property p_rdata_upper;
    s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000;
  endproperty
  a_rdata_upper: assert property (p_rdata_upper)
    else $error("upper read data bits not zero");

endmodule : eies_irq_ctrl

// ===== verif/eies_host_model.sv
// Purpose: AXI4-Lite host master that reaches the interrupt registers.
// Assumes: Tasks are entered just after a rising edge of aclk.
// Notes:   Released payload is inverted so stale data never looks valid.
`timescale 1ns/1ps
module eies_host_model (
  input  wire logic        aclk,
  output logic [11:0]      awaddr,
  output logic             awvalid,
  input  wire logic        awready,
  output logic [31:0]      wdata,
  output logic [3:0]       wstrb,
  output logic             wvalid,
  input  wire logic        wready,
  input  wire logic [1:0]  bresp,
  input  wire logic        bvalid,
  output logic             bready,
  output logic [11:0]      araddr,
  output logic             arvalid,
  input  wire logic        arready,
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  rresp,
  input  wire logic        rvalid,
  output logic             rready
);
  // Bus idle at time zero
  initial begin
    {awaddr, araddr, wdata} = 56'h0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    wstrb = 4'h0;
  end

  // One write; ones clear host-clearable flags, zeros leave them alone
  task automatic wr(input logic [11:0] a, input logic [15:0] d, output logic [1:0] resp);
    awaddr  <= a;
    wdata   <= {16'h0000, d};
    wstrb   <= 4'hF;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) begin
        awvalid <= 1'b0;
        awaddr  <= ~awaddr;
      end
      if (wvalid && wready) begin
        wvalid <= 1'b0;
        wdata  <= ~wdata;
      end
    end while (!(bvalid && bready));
    resp = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask : wr

  // One read; a read must leave flags as they were
  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] resp);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) begin
        arvalid <= 1'b0;
        araddr  <= ~araddr;
      end
    end while (!(rvalid && rready));
    d = rdata;
    resp = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask : rd
endmodule : eies_host_model

// ===== verif/tb.sv
// Purpose: Self-checking bench for the interrupt mask and flag block.
// Assumes: Events are one-cycle pulses on aclk; wake flags cleared by pm_wake_clear.
// Notes:   Each source is latched unmasked, then gated by its mask bit; delayed energy also waits for device_ready.
`timescale 1ns/1ps
module tb;
  logic        aclk, aresetn, link_up, device_ready, irq_out;
  logic [9:0]  ev;
  logic [3:0]  pm_wake_clear, wstrb;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rv;
  logic [1:0]  bresp, rresp, rs;
  logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  int          mismatches, checks;
  localparam int SRC_BIT [12] = '{15, 14, 13, 11, 9, 8, 6, 5, 4, 3, 2, 0};

  eies_irq_ctrl DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .link_up(link_up), .tx_done_evt(ev[0]), .rx_ready_evt(ev[1]),
    .rx_overrun_evt(ev[2]), .tx_stopped_evt(ev[3]), .rx_stopped_evt(ev[4]), .tx_space_evt(ev[5]),
    .wake_frame_evt(ev[6]), .magic_packet_evt(ev[7]), .linkup_wake_evt(ev[8]),
    .energy_wake_evt(ev[9]), .device_ready(device_ready), .pm_wake_clear(pm_wake_clear),
    .irq_out(irq_out));

  eies_host_model host (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

  // 40 MHz clock
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic close_out;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : close_out

  // Reset values, read-only bit and unmapped address
  task automatic t_regs;
    #1;
    chk("irq after reset", 32'h0, {31'h0, irq_out});
    host.rd(eies_pkg::ADDR_MASK, rv, rs);
    chk("mask reset", 32'h0000_0000, rv);
    host.rd(eies_pkg::ADDR_FLAGS, rv, rs);
    chk("flags reset", 32'h0000_0300, rv);
    host.wr(eies_pkg::ADDR_MASK, 16'hFFFF, rs);
    host.rd(eies_pkg::ADDR_MASK, rv, rs);
    chk("mask bit1 ro", 32'h0000_FFFD, rv);
    #1;
    chk("irq stopped", 32'h1, {31'h0, irq_out});
    host.wr(12'h244, 16'hFFFF, rs);
    chk("unmapped bresp", 32'h2, {30'h0, rs});
    host.rd(12'h244, rv, rs);
    chk("unmapped rresp", 32'h2, {30'h0, rs});
    chk("unmapped rdata", 32'h0, rv);
    host.wr(eies_pkg::ADDR_MASK, 16'h0000, rs);
    chk("write okay", 32'h0, {30'h0, rs});
  endtask : t_regs

  // One source: latch unmasked, gate by its mask bit, survive read and zero write
  task automatic t_src(input int k);
    int mb;
    int fb;
    mb = SRC_BIT[k];
    fb = (k == 11) ? 2 : mb;
    host.wr(eies_pkg::ADDR_FLAGS, 16'hFFFF, rs);
    pm_wake_clear <= 4'hF;
    @(posedge aclk);
    pm_wake_clear <= 4'h0;
    if (k == 0) link_up <= ~link_up;
    else ev[(k == 11) ? 9 : k - 1] <= 1'b1;
    @(posedge aclk);
    ev <= 10'h000;
    @(posedge aclk);
    host.rd(eies_pkg::ADDR_FLAGS, rv, rs);
    chk("flag set", 32'h1 << fb, rv);
    #1;
    chk("irq masked", 32'h0, {31'h0, irq_out});
    host.wr(eies_pkg::ADDR_MASK, 16'h1 << mb, rs);
    #1;
    chk("irq enabled", {31'h0, k != 11}, {31'h0, irq_out});
    if (k == 11) begin
      device_ready <= 1'b1;
      @(posedge aclk);
      #1;
      chk("irq delayed", 32'h1, {31'h0, irq_out});
      device_ready <= 1'b0;
    end
    host.wr(eies_pkg::ADDR_FLAGS, 16'h0000, rs);
    host.rd(eies_pkg::ADDR_FLAGS, rv, rs);
    chk("flag kept", 32'h1 << fb, rv);
    host.wr(eies_pkg::ADDR_MASK, 16'h0000, rs);
    #1;
    chk("irq disabled", 32'h0, {31'h0, irq_out});
    // Write one clears host-clearable flags; wake flags are left to power management
    host.wr(eies_pkg::ADDR_FLAGS, 16'h1 << fb, rs);
    host.rd(eies_pkg::ADDR_FLAGS, rv, rs);
    chk("flag cleared", (fb >= eies_pkg::WAKE_LO && fb < eies_pkg::WAKE_LO + eies_pkg::WAKE_W) ? 32'h1 << fb : 32'h0, rv);
  endtask : t_src

  // Main sequence
  initial begin
    aresetn = 1'b0;
    link_up = 1'b0;
    device_ready = 1'b0;
    ev = 10'h000;
    pm_wake_clear = 4'h0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs;
    for (int k = 0; k < 12; k++) t_src(k);
    t_src(0);
    t_src(3);
    close_out;
  end

  // Watchdog well beyond the expected few hundred cycles
  initial begin
    repeat (20000) @(posedge aclk);
    mismatches++;
    close_out;
  end
endmodule : tb
